// ---- src/ssr_status_regs.sv ----
`timescale 1ns/1ps
module ssr_status_regs #(
  parameter int QUEUE_DEPTH = ssr_pkg::GEST_QUEUE_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire logic [ssr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [ssr_pkg::DATA_W-1:0] reg_wdata,
  output logic [ssr_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // Ambient measurement
  input wire logic amb_done,
  input wire logic [ssr_pkg::AMB_W-1:0] amb_channel_zero,
  input wire logic [ssr_pkg::AMB_W-1:0] amb_channel_one,
  input wire logic [ssr_pkg::GAIN_W-1:0] amb_gain,
  input wire logic amb_invalid,
  input wire logic amb_out_of_range,
  // Proximity measurement
  input wire logic prox_done,
  input wire logic [ssr_pkg::PROX_W-1:0] prox_count,
  input wire logic prox_near,
  input wire logic prox_far,
  input wire logic prox_invalid,
  input wire logic prox_out_of_range,
  // Gesture datasets
  input wire logic gest_dataset,
  input wire logic gest_invalid,
  output logic gest_restart
);
  import ssr_pkg::*;

  // ----------------------------------------------------------------
  // Result holding registers
  // ----------------------------------------------------------------
  logic [AMB_W-1:0] amb_ch0;
  logic [AMB_W-1:0] amb_ch1;
  logic [GAIN_W-1:0] amb_gain_q;
  logic [PROX_W-1:0] prox_val;
  logic prox_near_q;
  logic prox_far_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      amb_ch0 <= RESULT_RESET;
      amb_ch1 <= RESULT_RESET;
      amb_gain_q <= '0;
    end else if (ce && amb_done) begin
      amb_ch0 <= amb_channel_zero;
      amb_ch1 <= amb_channel_one;
      amb_gain_q <= amb_gain;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prox_val <= '0;
      prox_near_q <= 1'b0;
      prox_far_q <= 1'b0;
    end else if (ce && prox_done) begin
      prox_val <= prox_count;
      prox_near_q <= prox_near;
      prox_far_q <= prox_far;
    end
  end

  // ----------------------------------------------------------------
  // Read side effects
  // ----------------------------------------------------------------
  logic amb_result_read;
  logic prox_result_read;
  logic gest_byte_read;
  logic gest_set_read;

  assign amb_result_read = reg_rd && (reg_addr >= AMB_CH0_LOW_OFF) && (reg_addr <= AMB_CH1_HIGH_OFF);
  assign prox_result_read = reg_rd && ((reg_addr == PROX_LOW_OFF) || (reg_addr == PROX_HIGH_OFF));
  assign gest_byte_read = reg_rd && (reg_addr >= GEST_FIRST_OFF) && (reg_addr <= GEST_LAST_OFF);
  assign gest_set_read = reg_rd && (reg_addr == GEST_LAST_OFF);

  // ----------------------------------------------------------------
  // Channel flags
  // ----------------------------------------------------------------
  logic amb_fresh;
  logic amb_irq;
  logic amb_bad;
  logic prox_fresh;
  logic prox_irq;
  logic prox_bad;

  ssr_chan_flags u_amb_flags (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .done(amb_done),
    .out_of_range(amb_out_of_range),
    .invalid_in(amb_invalid),
    .result_read(amb_result_read),
    .fresh(amb_fresh),
    .irq(amb_irq),
    .invalid(amb_bad)
  );

  ssr_chan_flags u_prox_flags (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .done(prox_done),
    .out_of_range(prox_out_of_range),
    .invalid_in(prox_invalid),
    .result_read(prox_result_read),
    .fresh(prox_fresh),
    .irq(prox_irq),
    .invalid(prox_bad)
  );

  // ----------------------------------------------------------------
  // Gesture queue tracking
  // ----------------------------------------------------------------
  logic [GEST_PTR_W-1:0] gest_count;
  logic gest_full;
  logic gest_irq;
  logic gest_fresh;
  logic gest_bad;

  ssr_gest_queue #(
    .DEPTH(QUEUE_DEPTH)
  ) u_gest_queue (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .dataset_in(gest_dataset),
    .invalid_in(gest_invalid),
    .dataset_read(gest_set_read),
    .byte_read(gest_byte_read),
    .count(gest_count),
    .full(gest_full),
    .irq(gest_irq),
    .fresh(gest_fresh),
    .invalid(gest_bad),
    .restart(gest_restart)
  );

  // ----------------------------------------------------------------
  // Status words
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] amb_status;
  logic [DATA_W-1:0] prox_status;
  logic [DATA_W-1:0] gest_status;

  always_comb begin
    amb_status = STATUS_RESET;
    amb_status[AMB_VALID_BIT] = amb_bad;
    amb_status[AMB_GAIN_LSB +: GAIN_W] = amb_gain_q;
    amb_status[AMB_IRQ_BIT] = amb_irq;
    amb_status[AMB_FRESH_BIT] = amb_fresh;
  end

  always_comb begin
    prox_status = STATUS_RESET;
    prox_status[PROX_NEAR_BIT] = prox_near_q;
    prox_status[PROX_FAR_BIT] = prox_far_q;
    prox_status[PROX_VALID_BIT] = prox_bad;
    prox_status[PROX_IRQ_BIT] = prox_irq;
    prox_status[PROX_FRESH_BIT] = prox_fresh;
  end

  always_comb begin
    gest_status = STATUS_RESET;
    gest_status[GEST_FILLED_BIT] = (gest_count != '0);
    gest_status[GEST_FULL_BIT] = gest_full;
    gest_status[GEST_VALID_BIT] = gest_bad;
    gest_status[GEST_IRQ_BIT] = gest_irq;
    gest_status[GEST_FRESH_BIT] = gest_fresh;
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] next_rdata;

  always_comb begin
    case (reg_addr)
      AMB_STATUS_OFF: next_rdata = amb_status;
      PROX_STATUS_OFF: next_rdata = prox_status;
      GEST_STATUS_OFF: next_rdata = gest_status;
      AMB_CH0_LOW_OFF: next_rdata = amb_ch0[7:0];
      AMB_CH0_HIGH_OFF: next_rdata = amb_ch0[15:8];
      AMB_CH1_LOW_OFF: next_rdata = amb_ch1[7:0];
      AMB_CH1_HIGH_OFF: next_rdata = amb_ch1[15:8];
      PROX_LOW_OFF: next_rdata = prox_val[7:0];
      PROX_HIGH_OFF: next_rdata = {5'h00, prox_val[PROX_W-1:8]};
      GEST_PTR_OFF: next_rdata = {2'h0, gest_count};
      default: next_rdata = UNMAPPED_READ;
    endcase
  end

  // Writes never reach any state here
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= UNMAPPED_READ;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  amb_status_read_a: assert property (ce && reg_rd && reg_addr == AMB_STATUS_OFF
      |=> reg_rvalid && reg_rdata[AMB_IRQ_BIT] == $past(amb_irq) && reg_rdata[7:6] == 2'h0)
    else $error("ambient status read returns wrong value");
  gest_reserved_a: assert property (ce && reg_rd && reg_addr == GEST_STATUS_OFF
      |=> reg_rdata[2:0] == 3'h0 && reg_rdata[GEST_FILLED_BIT] == ($past(gest_count) != '0))
    else $error("gesture status reserved or fill bit wrong");
  ch0_bytes_a: assert property (ce && amb_done ##1 ce && reg_rd && reg_addr == AMB_CH0_HIGH_OFF
      |=> reg_rdata == $past(amb_channel_zero[15:8], 2))
    else $error("channel zero high byte wrong");
  write_ignored_a: assert property (ce && reg_wr && !reg_rd && !amb_done && !prox_done && !gest_dataset
      |=> $stable(amb_status) && $stable(prox_status) && $stable(gest_status))
    else $error("register write changed status");
  near_capture_a: assert property (ce && prox_done |=> prox_status[PROX_NEAR_BIT] == $past(prox_near))
    else $error("near flag not captured");

  // ----------------------------------------------------------------
  // Read path checks
  // ----------------------------------------------------------------
  rvalid_follows_a: assert property (ce && reg_rd |=> reg_rvalid)
    else $error("read not answered in next cycle");
  rvalid_idle_a: assert property (ce && !reg_rd |=> !reg_rvalid)
    else $error("answer strobe without read");
  rdata_hold_a: assert property (ce && !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  unmapped_zero_a: assert property (ce && reg_rd && reg_addr < AMB_STATUS_OFF
      |=> reg_rdata == UNMAPPED_READ)
    else $error("unmapped offset did not read zero");
  frozen_state_a: assert property (!ce
      |=> $stable(reg_rvalid) && $stable(reg_rdata) && $stable(gest_restart))
    else $error("outputs moved while clock enable low");
  frozen_status_a: assert property (!ce
      |=> $stable(amb_status) && $stable(prox_status) && $stable(gest_status))
    else $error("status moved while clock enable low");
  ptr_read_a: assert property (ce && reg_rd && reg_addr == GEST_PTR_OFF
      |=> reg_rdata == {2'h0, $past(gest_count)})
    else $error("pointer read returns wrong value");

  // ----------------------------------------------------------------
  // Ambient checks
  // ----------------------------------------------------------------
  amb_valid_capture_a: assert property (ce && amb_done
      |=> amb_status[AMB_VALID_BIT] == $past(amb_invalid))
    else $error("ambient invalid flag not captured");
  amb_valid_hold_a: assert property (ce && !amb_done
      |=> $stable(amb_status[AMB_VALID_BIT]))
    else $error("ambient invalid flag moved without result");
  amb_irq_capture_a: assert property (ce && amb_done
      |=> amb_status[AMB_IRQ_BIT] == $past(amb_out_of_range))
    else $error("ambient interrupt not set from range");
  amb_fresh_set_a: assert property (ce && amb_done |=> amb_status[AMB_FRESH_BIT])
    else $error("ambient new data flag not set");
  amb_read_clear_a: assert property (ce && !amb_done && reg_rd && reg_addr == AMB_CH1_LOW_OFF
      |=> amb_status[AMB_IRQ_BIT:AMB_FRESH_BIT] == 2'b00)
    else $error("ambient result read did not clear flags");
  gain_capture_a: assert property (ce && amb_done
      |=> amb_status[AMB_GAIN_LSB +: GAIN_W] == $past(amb_gain))
    else $error("ambient gain range not captured");
  ch1_capture_a: assert property (ce && amb_done |=> amb_ch1 == $past(amb_channel_one))
    else $error("channel one result not captured");
  ch1_low_read_a: assert property (ce && reg_rd && reg_addr == AMB_CH1_LOW_OFF
      |=> reg_rdata == $past(amb_ch1[7:0]))
    else $error("channel one low byte wrong");
  ch0_low_read_a: assert property (ce && reg_rd && reg_addr == AMB_CH0_LOW_OFF
      |=> reg_rdata == $past(amb_ch0[7:0]))
    else $error("channel zero low byte wrong");

  // ----------------------------------------------------------------
  // Proximity checks
  // ----------------------------------------------------------------
  far_capture_a: assert property (ce && prox_done |=> prox_status[PROX_FAR_BIT] == $past(prox_far))
    else $error("far flag not captured");
  prox_valid_capture_a: assert property (ce && prox_done
      |=> prox_status[PROX_VALID_BIT] == $past(prox_invalid))
    else $error("proximity invalid flag not captured");
  prox_irq_capture_a: assert property (ce && prox_done
      |=> prox_status[PROX_IRQ_BIT] == $past(prox_out_of_range))
    else $error("proximity interrupt not set from range");
  prox_fresh_set_a: assert property (ce && prox_done |=> prox_status[PROX_FRESH_BIT])
    else $error("proximity new data flag not set");
  prox_read_clear_a: assert property (ce && !prox_done && reg_rd && reg_addr == PROX_LOW_OFF
      |=> prox_status[PROX_IRQ_BIT:PROX_FRESH_BIT] == 2'b00)
    else $error("proximity result read did not clear flags");
  prox_reserved_a: assert property (ce && reg_rd && reg_addr == PROX_STATUS_OFF
      |=> reg_rdata[7:5] == 3'h0)
    else $error("proximity status reserved bits not zero");

  // ----------------------------------------------------------------
  // Gesture checks
  // ----------------------------------------------------------------
  gest_accept_a: assert property (ce && gest_dataset && !gest_full
      |=> gest_status[GEST_FILLED_BIT] && gest_status[GEST_IRQ_BIT] && gest_status[GEST_FRESH_BIT])
    else $error("accepted dataset not flagged");
  gest_valid_capture_a: assert property (ce && gest_dataset && !gest_full
      |=> gest_status[GEST_VALID_BIT] == $past(gest_invalid))
    else $error("gesture invalid flag not captured");
  gest_full_flag_a: assert property (ce && gest_dataset && !gest_set_read
      && gest_count == GEST_PTR_W'(QUEUE_DEPTH - 1) |=> gest_status[GEST_FULL_BIT])
    else $error("gesture full flag not raised");
  gest_byte_clear_a: assert property (ce && !gest_dataset && reg_rd && reg_addr == GEST_FIRST_OFF
      |=> !gest_status[GEST_FRESH_BIT])
    else $error("gesture byte read did not clear new data flag");
  gest_empty_a: assert property (gest_count == '0
      |-> !gest_status[GEST_FILLED_BIT] && !gest_status[GEST_IRQ_BIT])
    else $error("empty queue still flagged");
  restart_pulse_a: assert property (ce && gest_restart |=> !gest_restart)
    else $error("restart held longer than one cycle");

  amb_read_cov: cover property (amb_irq ##1 ce && reg_rd && reg_addr == AMB_CH0_LOW_OFF);
  prox_far_cov: cover property (prox_status[PROX_FAR_BIT]);
endmodule

// ---- common/ssr_pkg.sv ----
package ssr_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int AMB_W = 16;
  localparam int PROX_W = 11;
  localparam int GAIN_W = 3;
  localparam int GEST_QUEUE_DEPTH = 32;
  localparam int GEST_PTR_W = 6;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] AMB_STATUS_OFF = 8'h9C;
  localparam logic [7:0] PROX_STATUS_OFF = 8'h9D;
  localparam logic [7:0] GEST_STATUS_OFF = 8'h9E;
  localparam logic [7:0] AMB_CH0_LOW_OFF = 8'hA4;
  localparam logic [7:0] AMB_CH0_HIGH_OFF = 8'hA5;
  localparam logic [7:0] AMB_CH1_LOW_OFF = 8'hA6;
  localparam logic [7:0] AMB_CH1_HIGH_OFF = 8'hA7;
  localparam logic [7:0] PROX_LOW_OFF = 8'hB0;
  localparam logic [7:0] PROX_HIGH_OFF = 8'hB1;
  localparam logic [7:0] GEST_PTR_OFF = 8'hB2;
  localparam logic [7:0] GEST_FIRST_OFF = 8'hB3;
  localparam logic [7:0] GEST_LAST_OFF = 8'hB6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AMB_VALID_BIT = 5;
  localparam int AMB_GAIN_LSB = 2;
  localparam int AMB_IRQ_BIT = 1;
  localparam int AMB_FRESH_BIT = 0;
  localparam int PROX_NEAR_BIT = 4;
  localparam int PROX_FAR_BIT = 3;
  localparam int PROX_VALID_BIT = 2;
  localparam int PROX_IRQ_BIT = 1;
  localparam int PROX_FRESH_BIT = 0;
  localparam int GEST_FILLED_BIT = 7;
  localparam int GEST_FULL_BIT = 6;
  localparam int GEST_VALID_BIT = 5;
  localparam int GEST_IRQ_BIT = 4;
  localparam int GEST_FRESH_BIT = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

endpackage

// ---- src/ssr_chan_flags.sv ----
`timescale 1ns/1ps
module ssr_chan_flags (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Measurement events
  input wire logic done,
  input wire logic out_of_range,
  input wire logic invalid_in,
  input wire logic result_read,
  // Flags
  output logic fresh,
  output logic irq,
  output logic invalid
);
  import ssr_pkg::*;

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fresh <= 1'b0;
    end else if (ce) begin
      if (done) begin
        fresh <= 1'b1;
      end else if (result_read) begin
        fresh <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (ce) begin
      if (done) begin
        irq <= out_of_range;
      end else if (result_read) begin
        irq <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      invalid <= 1'b0;
    end else if (ce && done) begin
      invalid <= invalid_in;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  irq_follows_range_a: assert property (ce && done |=> irq == $past(out_of_range))
    else $error("interrupt flag does not follow range of new result");
  irq_read_clear_a: assert property (ce && !done && result_read |=> !irq)
    else $error("interrupt flag not cleared by result read");
  fresh_set_wins_a: assert property (ce && done && result_read |=> fresh)
    else $error("new result lost against simultaneous read");
  fresh_read_cov: cover property (ce && done ##[1:20] ce && result_read && !done);
endmodule

// ---- src/ssr_gest_queue.sv ----
`timescale 1ns/1ps
module ssr_gest_queue #(
  parameter int DEPTH = ssr_pkg::GEST_QUEUE_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Dataset events
  input wire logic dataset_in,
  input wire logic invalid_in,
  input wire logic dataset_read,
  input wire logic byte_read,
  // State
  output logic [ssr_pkg::GEST_PTR_W-1:0] count,
  output logic full,
  output logic irq,
  output logic fresh,
  output logic invalid,
  output logic restart
);
  import ssr_pkg::*;

  logic accept;
  logic take;
  logic last_take;

  // ----------------------------------------------------------------
  // Occupancy
  // ----------------------------------------------------------------
  assign full = (count == GEST_PTR_W'(DEPTH));
  assign accept = dataset_in && !full;
  assign take = dataset_read && (count != '0);
  assign last_take = take && (count == GEST_PTR_W'(1)) && !accept;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count <= '0;
    end else if (ce) begin
      count <= count + GEST_PTR_W'(accept) - GEST_PTR_W'(take);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (ce) begin
      if (accept) begin
        irq <= 1'b1;
      end else if (last_take) begin
        irq <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      restart <= 1'b0;
    end else if (ce) begin
      restart <= last_take;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fresh <= 1'b0;
    end else if (ce) begin
      if (accept) begin
        fresh <= 1'b1;
      end else if (byte_read) begin
        fresh <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      invalid <= 1'b0;
    end else if (ce && accept) begin
      invalid <= invalid_in;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  drop_when_full_a: assert property (ce && full && dataset_in && !dataset_read |=> full)
    else $error("dataset accepted while queue full");
  ptr_decrement_a: assert property (ce && take && !accept |=> count == $past(count) - 6'h01)
    else $error("read dataset did not decrement pointer");
  irq_hold_a: assert property (irq && !(ce && last_take) |=> irq)
    else $error("gesture interrupt dropped before drain");
  drain_restart_a: assert property (ce && last_take |=> restart && !irq && count == '0)
    else $error("drain did not clear interrupt and restart");
  full_cov: cover property (full && ce && dataset_in);
  drain_cov: cover property (restart);
endmodule

// ---- testbench/ssr_host_model.sv ----
`timescale 1ns/1ps
module ssr_host_model (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic [ssr_pkg::ADDR_W-1:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [ssr_pkg::DATA_W-1:0] reg_wdata
);
  import ssr_pkg::*;

  initial begin
    reg_addr = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end

  // Released lines show the inverse, not a stale value
  task automatic rd(input logic [7:0] a, input bit hold);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    if (!hold) begin
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // One dataset, four bytes in order
  task automatic rd_set();
    for (int i = 0; i < 4; i++) rd(GEST_FIRST_OFF + 8'(i), i < 3);
  endtask
endmodule

// ---- testbench/tb_ssr_status_regs.sv ----
`timescale 1ns/1ps
module tb_ssr_status_regs;
  import ssr_pkg::*;
  localparam int DEPTH = 4;
  logic ref_clk;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_rd, reg_wr, reg_rvalid, gest_restart;
  logic amb_done = 1'b0;
  logic [15:0] amb_channel_zero = 16'h0000;
  logic [15:0] amb_channel_one = 16'h0000;
  logic [2:0] amb_gain = 3'h0;
  logic amb_invalid = 1'b0;
  logic amb_out_of_range = 1'b0;
  logic prox_done = 1'b0;
  logic [10:0] prox_count = 11'h000;
  logic prox_near = 1'b0;
  logic prox_far = 1'b0;
  logic prox_invalid = 1'b0;
  logic prox_out_of_range = 1'b0;
  logic gest_dataset = 1'b0;
  logic gest_invalid = 1'b0;
  logic [7:0] exp_q[$];
  logic [15:0] c0, c1;
  logic [2:0] g;
  logic [10:0] pc;
  int num_errors = 0;
  int total_checks = 0;
  int restarts = 0;
  logic [7:0] offs[8] = '{AMB_STATUS_OFF, PROX_STATUS_OFF, GEST_STATUS_OFF,
    AMB_CH0_LOW_OFF, AMB_CH0_HIGH_OFF, AMB_CH1_LOW_OFF, AMB_CH1_HIGH_OFF, 8'h50};

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  ssr_status_regs #(.QUEUE_DEPTH(DEPTH)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .amb_done(amb_done), .amb_channel_zero(amb_channel_zero), .amb_channel_one(amb_channel_one),
    .amb_gain(amb_gain), .amb_invalid(amb_invalid), .amb_out_of_range(amb_out_of_range),
    .prox_done(prox_done), .prox_count(prox_count), .prox_near(prox_near), .prox_far(prox_far),
    .prox_invalid(prox_invalid), .prox_out_of_range(prox_out_of_range),
    .gest_dataset(gest_dataset), .gest_invalid(gest_invalid), .gest_restart(gest_restart)
  );

  ssr_host_model host (
    .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata)
  );

  // ------------------------------------------------
  // Checking
  // ------------------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Oldest note against each answer; an unasked answer is an error
  always @(posedge ref_clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() > 0) chk_byte(reg_rdata, exp_q.pop_front());
      else chk_byte(8'(reg_rvalid), 8'h00);
    end
    if (gest_restart === 1'b1) restarts <= restarts + 1;
  end

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #80000;
    num_errors++;
    report_and_stop();
  end

  // ------------------------------------------------
  // Stimulus
  // ------------------------------------------------
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e, input bit hold);
    exp_q.push_back(e);
    host.rd(a, hold);
  endtask

  task automatic rd_set();
    repeat (4) exp_q.push_back(8'h00);
    host.rd_set();
  endtask

  task automatic amb_ev(input logic [15:0] a0, a1, input logic [2:0] gn, input logic inv, oor);
    @(posedge ref_clk);
    amb_done <= 1'b1;
    amb_channel_zero <= a0;
    amb_channel_one <= a1;
    amb_gain <= gn;
    amb_invalid <= inv;
    amb_out_of_range <= oor;
    @(posedge ref_clk);
    amb_done <= 1'b0;
  endtask

  task automatic prox_ev(input logic [10:0] n, input logic nr, fr, inv, oor);
    @(posedge ref_clk);
    prox_done <= 1'b1;
    prox_count <= n;
    prox_near <= nr;
    prox_far <= fr;
    prox_invalid <= inv;
    prox_out_of_range <= oor;
    @(posedge ref_clk);
    prox_done <= 1'b0;
  endtask

  // Back-to-back datasets, only the last one flagged invalid
  task automatic gest_ev(input int n, input logic inv_last);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      gest_dataset <= 1'b1;
      gest_invalid <= inv_last && (i == n - 1);
    end
    @(posedge ref_clk);
    gest_dataset <= 1'b0;
  endtask

  // ------------------------------------------------
  // Tests
  // ------------------------------------------------
  initial begin
    void'($urandom(32'h7644330b));
    c0 = 16'($urandom());
    c1 = 16'($urandom());
    g = 3'($urandom_range(5, 0));
    pc = 11'($urandom());
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (offs[i]) rd_exp(offs[i], 8'h00, 1'b0);
    amb_ev(c0, c1, g, 1'b1, 1'b1);
    foreach (offs[i]) host.wr(offs[i], 8'($urandom()));
    rd_exp(AMB_STATUS_OFF, {2'b00, 1'b1, g, 2'b11}, 1'b0);
    rd_exp(AMB_CH0_LOW_OFF, c0[7:0], 1'b1);
    rd_exp(AMB_CH0_HIGH_OFF, c0[15:8], 1'b1);
    rd_exp(AMB_CH1_LOW_OFF, c1[7:0], 1'b1);
    rd_exp(AMB_CH1_HIGH_OFF, c1[15:8], 1'b0);
    rd_exp(AMB_STATUS_OFF, {2'b00, 1'b1, g, 2'b00}, 1'b0);
    amb_ev(c0, c1, g, 1'b0, 1'b1);
    rd_exp(AMB_STATUS_OFF, {3'b000, g, 2'b11}, 1'b0);
    amb_ev(c0, c1, g, 1'b0, 1'b0);
    rd_exp(AMB_STATUS_OFF, {3'b000, g, 2'b01}, 1'b0);
    repeat (3) @(posedge ref_clk);
    ce <= 1'b0;
    host.rd(AMB_STATUS_OFF, 1'b0);
    amb_ev(~c0, c1, g ^ 3'b001, 1'b1, 1'b1);
    @(posedge ref_clk);
    ce <= 1'b1;
    rd_exp(AMB_STATUS_OFF, {3'b000, g, 2'b01}, 1'b0);
    rd_exp(AMB_CH0_LOW_OFF, c0[7:0], 1'b0);
    fork
      amb_ev(c1, c0, g, 1'b0, 1'b0);
      begin
        @(posedge ref_clk);
        rd_exp(AMB_CH0_HIGH_OFF, c1[15:8], 1'b0);
      end
    join
    prox_ev(pc, 1'b1, 1'b0, 1'b1, 1'b1);
    rd_exp(PROX_STATUS_OFF, 8'h17, 1'b0);
    rd_exp(PROX_LOW_OFF, pc[7:0], 1'b1);
    rd_exp(PROX_HIGH_OFF, {5'b00000, pc[10:8]}, 1'b0);
    rd_exp(PROX_STATUS_OFF, 8'h14, 1'b0);
    prox_ev(~pc, 1'b0, 1'b1, 1'b0, 1'b1);
    rd_exp(PROX_STATUS_OFF, 8'h0B, 1'b0);
    gest_ev(1, 1'b1);
    rd_exp(GEST_STATUS_OFF, 8'hB8, 1'b0);
    gest_ev(DEPTH, 1'b1);
    rd_exp(GEST_STATUS_OFF, 8'hD8, 1'b0);
    rd_exp(GEST_PTR_OFF, 8'(DEPTH), 1'b0);
    repeat (DEPTH - 1) rd_set();
    rd_exp(GEST_STATUS_OFF, 8'h90, 1'b0);
    rd_exp(GEST_PTR_OFF, 8'h01, 1'b0);
    chk_cnt(restarts, 0);
    rd_set();
    rd_exp(GEST_STATUS_OFF, 8'h00, 1'b0);
    repeat (4) @(posedge ref_clk);
    chk_cnt(restarts, 1);
    chk_cnt(exp_q.size(), 0);
    report_and_stop();
  end
endmodule
